// ### hw/etr_map.svh
// Purpose: Register offsets, field layouts and timing constants of the tracking reference block.
// Assumes: A 10 MHz system clock.
// Notes: Definitions only.
`ifndef ETR_MAP_SVH
`define ETR_MAP_SVH

// ***********************************************************************
// Register map
// ***********************************************************************
`define ETR_ADDR_CLIP_MASK 8'h20
`define ETR_ADDR_CLIP_FLAGS 8'h22
`define ETR_NUM_CONV 5
`define ETR_TRACK_CONV 4
`define ETR_FLAGS_RESET 5'h00
`define ETR_MASK_RESET 5'h00

// ***********************************************************************
// Data path
// ***********************************************************************
`define ETR_SAMPLE_W 24
`define ETR_FULL_SCALE 24'h7FFFFF
`define ETR_NEG_FULL_SCALE 24'h800000
`define ETR_OFFSET_STEP 25'h0040000
`define ETR_GAIN_SEL_MAX 8'hED
`define ETR_GAIN_FRAC_SHIFT 14
`define ETR_DECAY_SHIFT 6
`define ETR_NUM_SLOTS 32

// ***********************************************************************
// Timing
// ***********************************************************************
`define ETR_CLK_MHZ 10
`define ETR_DELAY_MIN_US 100
`define ETR_DELAY_MAX_US 500
`define ETR_DELAY_MIN_CYC (`ETR_DELAY_MIN_US * `ETR_CLK_MHZ)
`define ETR_DELAY_MAX_CYC (`ETR_DELAY_MAX_US * `ETR_CLK_MHZ)
`define ETR_DELAY_STEPS 15
`define ETR_STAMP_W 16

`endif

// ### hw/etr_pkg.sv
// Purpose: Shared types of the tracking reference block.
// Assumes: Included map header supplies all numeric constants.
// Notes: Types only.
`include "etr_map.svh"

package etr_pkg;
    typedef struct packed {
        logic [1:0] ch;
        logic [`ETR_SAMPLE_W-1:0] data;
    } audio_sample_type;

    typedef struct packed {
        logic [`ETR_STAMP_W-1:0] stamp;
        audio_sample_type sample;
    } delay_entry_type;
endpackage : etr_pkg

// ### hw/sync_fifo.sv
// Purpose: Small synchronous FIFO with valid and ready on both sides.
// Assumes: One clock; DEPTH is a power of two.
// Notes: Full and empty are exact; a full FIFO drops inReady.
`timescale 1ns/1ns

module sync_fifo #(
    parameter int WIDTH = 26,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wrPtr_q;
    logic [AW:0] rdPtr_q;
    wire logic push = inValid && inReady;
    wire logic pop = outValid && outReady;

    assign inReady = (wrPtr_q - rdPtr_q) != (AW+1)'(DEPTH);
    assign outValid = wrPtr_q != rdPtr_q;
    assign outData = mem[rdPtr_q[AW-1:0]];

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wrPtr_q[AW-1:0]] <= inData;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end else begin
            wrPtr_q <= wrPtr_q + (AW+1)'(push);
            rdPtr_q <= rdPtr_q + (AW+1)'(pop);
        end
    end
endmodule : sync_fifo

// ### hw/envelope_tracking_reference.sv
// Purpose: Tracking reference generator with audio group delay and sticky clip flags.
// Assumes: Host slots, audio samples and register strobes arrive on clk_sys.
// Notes: Overview of operation follows.
//
// Overview of operation
// (RQ1) Reference follows the peak magnitude over enabled slots, up to 32 slots.
// (RQ2) Processed reference leaves on the fifth converter output after offset and gain.
// (RQ3) A three-bit headroom field adds a static offset, in steps of 1/32 of full scale.
// (RQ4) Audio samples are delayed; the reference is not, so the supply leads.
// (RQ5) A four-bit field sets the audio delay from 100 us to 500 us.
// (RQ6) Gain stage spans +6 dB down to -83 dB in about 0.4 dB steps.
// (RQ7) One sticky clip flag per converter, converters one to five in bits 0 to 4.
// (RQ8) Clip flags are read-only at address 22h; upper three bits read zero.
// (RQ9) With auto-mask mode 0, reading a set flag sets its mask bit.
// (RQ10) A clip raises the interrupt pin only while its mask bit is 0.
// (RQ11) Reading the flags clears the flags that the read returned.
`timescale 1ns/1ns
`include "etr_map.svh"

module envelope_tracking_reference
    import etr_pkg::*;
#(
    parameter int MIN_DELAY_CYC = `ETR_DELAY_MIN_CYC,
    parameter int MAX_DELAY_CYC = `ETR_DELAY_MAX_CYC,
    parameter int DELAY_DEPTH = 256,
    parameter int FIFO_DEPTH = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Tracking slots from the host
    input wire logic trackValid,
    input wire logic [4:0] trackSlot,
    input wire logic [`ETR_SAMPLE_W-1:0] trackData,
    input wire logic trackFrameEnd,
    input wire logic [`ETR_NUM_SLOTS-1:0] channelEnable,
    // Controls
    input wire logic [2:0] headroom_offset_sel,
    input wire logic [7:0] tracking_gain_sel,
    input wire logic [3:0] groupDelaySel,
    input wire logic autoMaskOff,
    // Fifth converter output
    output logic [`ETR_SAMPLE_W-1:0] trackRef,
    output logic trackRefValid,
    // Audio samples in
    input wire logic audioValid,
    output logic audioReady,
    input wire audio_sample_type audioIn,
    // Delayed audio to converters one to four
    output logic dacValid,
    input wire logic dacReady,
    output audio_sample_type dacOut,
    // Register port
    input wire logic regRd,
    input wire logic regWr,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    // Interrupt
    output logic intOut
);
    // ***********************************************************************
    // Helper functions
    // ***********************************************************************
    function automatic logic [`ETR_SAMPLE_W-1:0] magnitude(input logic [`ETR_SAMPLE_W-1:0] x);
        magnitude = x[`ETR_SAMPLE_W-1] ? (~x + 24'h000001) : x;
    endfunction : magnitude

    // Mantissa of 2^(-f/16) in Q1.15; each step is close to 0.376 dB.
    function automatic logic [15:0] gainMantissa(input logic [3:0] f);
        case (f)
            4'h0: gainMantissa = 16'h8000;
            4'h1: gainMantissa = 16'h7A93;
            4'h2: gainMantissa = 16'h7560;
            4'h3: gainMantissa = 16'h7066;
            4'h4: gainMantissa = 16'h6BA2;
            4'h5: gainMantissa = 16'h6712;
            4'h6: gainMantissa = 16'h62B4;
            4'h7: gainMantissa = 16'h5E84;
            4'h8: gainMantissa = 16'h5A82;
            4'h9: gainMantissa = 16'h56AC;
            4'hA: gainMantissa = 16'h52FF;
            4'hB: gainMantissa = 16'h4F7B;
            4'hC: gainMantissa = 16'h4C1C;
            4'hD: gainMantissa = 16'h48E2;
            4'hE: gainMantissa = 16'h45CB;
            4'hF: gainMantissa = 16'h42D5;
            default: gainMantissa = 16'h8000;
        endcase
    endfunction : gainMantissa

    // ***********************************************************************
    // Peak envelope
    // ***********************************************************************
    logic [`ETR_SAMPLE_W-1:0] peak_q;
    logic [`ETR_SAMPLE_W-1:0] env_q;
    logic refStage_q;
    wire logic slotTaken = trackValid && channelEnable[trackSlot];
    wire logic [`ETR_SAMPLE_W-1:0] slotMag = magnitude(trackData);
    wire logic [`ETR_SAMPLE_W-1:0] envDecay = env_q - (env_q >> `ETR_DECAY_SHIFT);
    wire logic [`ETR_SAMPLE_W-1:0] envNext = (peak_q >= envDecay) ? peak_q : envDecay;

    // Slow decay keeps the supply from chasing each zero crossing of the audio.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            peak_q <= '0;
            env_q <= '0;
            refStage_q <= 1'b0;
        end else begin
            if (trackFrameEnd) begin
                peak_q <= '0;
            end else if (slotTaken && slotMag > peak_q) begin
                peak_q <= slotMag; // RQ1
            end
            if (trackFrameEnd) begin
                env_q <= envNext; // RQ1
            end
            refStage_q <= trackFrameEnd;
        end
    end

    // ***********************************************************************
    // Headroom offset and gain stage
    // ***********************************************************************
    wire logic [7:0] gainIdx = (tracking_gain_sel > `ETR_GAIN_SEL_MAX) ?
        `ETR_GAIN_SEL_MAX : tracking_gain_sel;
    wire logic [24:0] offsetSum = {1'b0, env_q} + // RQ3
        25'(headroom_offset_sel) * `ETR_OFFSET_STEP;
    wire logic [40:0] gainProd = 41'(offsetSum) * 41'(gainMantissa(gainIdx[3:0]));
    wire logic [40:0] gainOut = gainProd >> (`ETR_GAIN_FRAC_SHIFT + 32'(gainIdx[7:4])); // RQ6
    wire logic refClip = gainOut > 41'(`ETR_FULL_SCALE);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            trackRef <= '0;
            trackRefValid <= 1'b0;
        end else begin
            trackRefValid <= refStage_q;
            if (refStage_q) begin
                trackRef <= refClip ? `ETR_FULL_SCALE : gainOut[`ETR_SAMPLE_W-1:0]; // RQ2
            end
        end
    end

    // ***********************************************************************
    // Audio group delay
    // ***********************************************************************
    localparam int DAW = $clog2(DELAY_DEPTH);
    delay_entry_type dlyMem [DELAY_DEPTH];
    logic [DAW:0] dlyWr_q;
    logic [DAW:0] dlyRd_q;
    logic [`ETR_STAMP_W-1:0] now_q;
    logic fifoInReady;
    wire logic [31:0] delayCyc32 = MIN_DELAY_CYC +
        (32'(groupDelaySel) * (MAX_DELAY_CYC - MIN_DELAY_CYC)) / `ETR_DELAY_STEPS; // RQ5
    wire logic [`ETR_STAMP_W-1:0] delayCyc = delayCyc32[`ETR_STAMP_W-1:0];
    wire delay_entry_type headEntry = dlyMem[dlyRd_q[DAW-1:0]];
    wire logic [`ETR_STAMP_W-1:0] headAge = now_q - headEntry.stamp;
    wire logic dlyEmpty = dlyWr_q == dlyRd_q;
    wire logic headAged = !dlyEmpty && headAge >= delayCyc; // RQ4
    wire logic dlyPop = headAged && fifoInReady;
    wire logic dlyPush = audioValid && audioReady;

    assign audioReady = (dlyWr_q - dlyRd_q) != (DAW+1)'(DELAY_DEPTH);

    always_ff @(posedge clk_sys) begin
        if (dlyPush) begin
            dlyMem[dlyWr_q[DAW-1:0]] <= '{stamp: now_q, sample: audioIn};
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            dlyWr_q <= '0;
            dlyRd_q <= '0;
            now_q <= '0;
        end else begin
            dlyWr_q <= dlyWr_q + (DAW+1)'(dlyPush);
            dlyRd_q <= dlyRd_q + (DAW+1)'(dlyPop);
            now_q <= now_q + 16'h0001;
        end
    end

    sync_fifo #(
        .WIDTH($bits(audio_sample_type)),
        .DEPTH(FIFO_DEPTH)
    ) outFifo (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .inValid(headAged),
        .inReady(fifoInReady),
        .inData(headEntry.sample),
        .outValid(dacValid),
        .outReady(dacReady),
        .outData(dacOut)
    );

    // ***********************************************************************
    // Clip flags, mask and interrupt
    // ***********************************************************************
    logic [`ETR_NUM_CONV-1:0] converter_clip_flag;
    logic [`ETR_NUM_CONV-1:0] converter_clip_irq_mask;
    wire logic dacTaken = dacValid && dacReady;
    wire logic dacAtRail = dacOut.data == `ETR_FULL_SCALE || dacOut.data == `ETR_NEG_FULL_SCALE;
    wire logic [3:0] audioClip = (dacTaken && dacAtRail) ? (4'h1 << dacOut.ch) : 4'h0;
    wire logic [`ETR_NUM_CONV-1:0] clipEvent = {refStage_q && refClip, audioClip};
    wire logic flagRead = regRd && regAddr == `ETR_ADDR_CLIP_FLAGS;
    wire logic maskWrite = regWr && regAddr == `ETR_ADDR_CLIP_MASK;
    wire logic [`ETR_NUM_CONV-1:0] flagsCleared = flagRead ? converter_clip_flag : '0;
    wire logic [`ETR_NUM_CONV-1:0] autoMask = (flagRead && !autoMaskOff) ?
        converter_clip_flag : '0;
    wire logic [`ETR_NUM_CONV-1:0] maskBase = maskWrite ?
        regWrData[`ETR_NUM_CONV-1:0] : converter_clip_irq_mask;
    wire logic [7:0] rdMux = flagRead ? {3'h0, converter_clip_flag} : // RQ8
        (regAddr == `ETR_ADDR_CLIP_MASK) ? {3'h0, converter_clip_irq_mask} : 8'h00;

    // A clip in the same cycle as the clearing read survives; set wins over clear.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            converter_clip_flag <= `ETR_FLAGS_RESET;
            converter_clip_irq_mask <= `ETR_MASK_RESET;
            regRdData <= 8'h00;
            intOut <= 1'b0;
        end else begin
            converter_clip_flag <= (converter_clip_flag & ~flagsCleared) | clipEvent; // RQ7 RQ11
            converter_clip_irq_mask <= maskBase | autoMask; // RQ9
            if (regRd) begin
                regRdData <= rdMux;
            end
            intOut <= |(converter_clip_flag & ~converter_clip_irq_mask); // RQ10
        end
    end

    // ***********************************************************************
    // Checks
    // ***********************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence clipFlagRead;
        flagRead && converter_clip_flag != '0 && clipEvent == '0;
    endsequence

    a_ref_follows_frame: assert property (trackFrameEnd |-> ##2 trackRefValid) // RQ2
        else $error("Reference did not follow frame end by two cycles.");
    a_ref_within_scale: assert property (trackRefValid |-> trackRef <= `ETR_FULL_SCALE) // RQ6
        else $error("Reference exceeds full scale.");
    a_env_holds_peak: assert property (trackFrameEnd |=> env_q >= $past(peak_q)) // RQ1
        else $error("Envelope fell below frame peak.");
    a_delay_min_age: assert property (dlyPop |-> headAge >= delayCyc && // RQ4 RQ5
        delayCyc >= 16'(MIN_DELAY_CYC) && delayCyc <= 16'(MAX_DELAY_CYC))
        else $error("Audio sample released outside its delay span.");
    a_flag_set_sticky: assert property (clipEvent[4] |=> converter_clip_flag[4]) // RQ7
        else $error("Clip event did not set its flag.");
    a_read_clears_flags: assert property (clipFlagRead |=> converter_clip_flag == '0) // RQ11
        else $error("Read did not clear returned flags.");
    a_read_returns_flags: assert property (flagRead |=> // RQ8
        regRdData == {3'h0, $past(converter_clip_flag)})
        else $error("Flag read data wrong.");
    a_auto_mask_set: assert property (flagRead && !autoMaskOff |=> // RQ9
        (converter_clip_irq_mask & $past(converter_clip_flag)) == $past(converter_clip_flag))
        else $error("Auto-mask did not set mask bits.");
    a_mask_kept_mode1: assert property (regRd && autoMaskOff && !maskWrite |=> // RQ9
        $stable(converter_clip_irq_mask))
        else $error("Mask changed with auto-mask off.");
    a_int_gated_mask: assert property (##1 intOut == // RQ10
        |($past(converter_clip_flag) & ~$past(converter_clip_irq_mask)))
        else $error("Interrupt pin does not follow unmasked flags.");
endmodule : envelope_tracking_reference

// ### test/track_host_model.sv
// Purpose: Host model that drives tracking slots and audio samples into the block.
// Assumes: Requests change at the falling edge; slots last one cycle, audio is held until taken or maxWait cycles pass.
// Notes: Released data lines show the inverse of their last value.
`timescale 1ns/1ns
`include "etr_map.svh"

module track_host_model
    import etr_pkg::*;
(
    // Clock
    input wire logic clk_sys,
    // Tracking slots
    output logic trackValid,
    output logic [4:0] trackSlot,
    output logic [`ETR_SAMPLE_W-1:0] trackData,
    output logic trackFrameEnd,
    // Audio samples
    output logic audioValid,
    input wire logic audioReady,
    output audio_sample_type audioIn
);
    initial begin
        trackValid = 1'b0;
        trackSlot = 5'h00;
        trackData = 24'h000000;
        trackFrameEnd = 1'b0;
        audioValid = 1'b0;
        audioIn = '0;
    end

    task automatic sendSlot(input logic [4:0] s, input logic [23:0] d);
        @(negedge clk_sys);
        trackValid = 1'b1;
        trackSlot = s;
        trackData = d;
        @(negedge clk_sys);
        trackValid = 1'b0;
        trackData = ~d;
    endtask : sendSlot

    // The frame end gets a cycle of its own, since a slot beside it is dropped.
    task automatic endFrame();
        @(negedge clk_sys);
        trackFrameEnd = 1'b1;
        @(negedge clk_sys);
        trackFrameEnd = 1'b0;
    endtask : endFrame

    task automatic sendAudio(input audio_sample_type a, input int maxWait, output bit taken);
        int n;
        n = 0;
        taken = 1'b0;
        @(negedge clk_sys);
        audioValid = 1'b1;
        audioIn = a;
        while (!taken && n < maxWait) begin
            @(posedge clk_sys);
            taken = audioReady;
            n++;
        end
        @(negedge clk_sys);
        audioValid = 1'b0;
        audioIn = ~a;
    endtask : sendAudio
endmodule : track_host_model

// ### test/envelope_tracking_reference_tb.sv
// Purpose: Self-checking bench of the tracking reference block.
// Assumes: Delay bounds shortened to 10 and 50 cycles.
// Notes: Expected reads and audio samples are queued by the driver.
`timescale 1ns/1ns

module envelope_tracking_reference_tb
    import etr_pkg::*;
;
    localparam int MIN_D = 10;
    localparam int MAX_D = 50;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic trackValid, trackFrameEnd, trackRefValid, audioValid, audioReady, dacValid, intOut;
    logic [4:0] trackSlot;
    logic [23:0] trackData, trackRef;
    logic [31:0] channelEnable = '1;
    logic [2:0] headroom_offset_sel = 3'h0;
    logic [7:0] tracking_gain_sel = 8'h10;
    logic [3:0] groupDelaySel = 4'h0;
    logic autoMaskOff = 1'b0;
    logic dacReady = 1'b1;
    logic regRd = 1'b0;
    logic regWr = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic [7:0] regRdData;
    logic rdTaken;
    audio_sample_type audioIn, dacOut;
    logic [7:0] regQ[$];
    audio_sample_type audQ[$];
    int errors = 0;
    int checks = 0;

    always #50 clk_sys = ~clk_sys;

    track_host_model host (.clk_sys(clk_sys), .trackValid(trackValid), .trackSlot(trackSlot),
        .trackData(trackData), .trackFrameEnd(trackFrameEnd), .audioValid(audioValid),
        .audioReady(audioReady), .audioIn(audioIn));

    envelope_tracking_reference #(.MIN_DELAY_CYC(MIN_D), .MAX_DELAY_CYC(MAX_D)) uut (
        .clk_sys(clk_sys), .rstn(rstn), .trackValid(trackValid), .trackSlot(trackSlot),
        .trackData(trackData), .trackFrameEnd(trackFrameEnd), .channelEnable(channelEnable),
        .headroom_offset_sel(headroom_offset_sel), .tracking_gain_sel(tracking_gain_sel),
        .groupDelaySel(groupDelaySel), .autoMaskOff(autoMaskOff), .trackRef(trackRef),
        .trackRefValid(trackRefValid), .audioValid(audioValid), .audioReady(audioReady),
        .audioIn(audioIn), .dacValid(dacValid), .dacReady(dacReady), .dacOut(dacOut),
        .regRd(regRd), .regWr(regWr), .regAddr(regAddr), .regWrData(regWrData),
        .regRdData(regRdData), .intOut(intOut));

    task automatic checkVal(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : checkVal

    task automatic print_verdict();
        $display("Checks made %0d, mismatches %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict

    // ****************************************************************
    // Result watchers
    // ****************************************************************
    always @(posedge clk_sys) rdTaken <= regRd;
    always @(negedge clk_sys) begin
        if (rdTaken === 1'b1) begin
            if (regQ.size() == 0) checkVal("unexpected read", 0, 1);
            else checkVal("regRdData", regQ.pop_front(), regRdData);
        end
    end
    always @(posedge clk_sys) begin
        if (dacValid === 1'b1 && dacReady === 1'b1) begin
            if (audQ.size() == 0) checkVal("unexpected sample", 0, 1);
            else checkVal("dacOut", audQ.pop_front(), dacOut);
        end
    end

    // ****************************************************************
    // Drivers
    // ****************************************************************
    task automatic rw(input logic wr, input logic [7:0] addr, input logic [7:0] d);
        @(negedge clk_sys);
        regWr = wr;
        regRd = !wr;
        regAddr = addr;
        regWrData = d;
        if (!wr) regQ.push_back(d);
        @(negedge clk_sys);
        regRd = 1'b0;
        regWr = 1'b0;
    endtask : rw

    task automatic frame(input logic [4:0] s, input logic [23:0] d, output logic [23:0] r);
        int n;
        n = 0;
        host.sendSlot(s, d);
        host.endFrame();
        while (trackRefValid !== 1'b1 && n < 8) begin
            @(negedge clk_sys);
            n++;
        end
        checkVal("trackRefValid latency", 1, n);
        r = trackRef;
    endtask : frame

    task automatic audio(input logic [1:0] ch, input logic [23:0] d, output bit ok);
        host.sendAudio({ch, d}, 20, ok);
        if (ok) audQ.push_back({ch, d});
    endtask : audio

    // Random readiness stalls the far side while the queue drains.
    task automatic drain(input bit randomReady);
        int k;
        k = 0;
        while (audQ.size() != 0 && k < 3000) begin
            @(negedge clk_sys);
            dacReady = randomReady ? 1'($urandom) : 1'b1;
            k++;
        end
        @(negedge clk_sys);
        dacReady = 1'b1;
        repeat (3) @(negedge clk_sys);
        checkVal("audio drained", 0, audQ.size());
    endtask : drain

    initial begin
        #3000000;
        errors++;
        print_verdict();
    end

    initial begin
        logic [23:0] r0, r1, r2;
        logic [4:0] s;
        int d, n;
        bit ok;
        void'($urandom(32'h35CE));
        repeat (10) @(posedge clk_sys);
        @(negedge clk_sys);
        rstn = 1'b1;
        rw(0, 8'h22, 8'h00);
        rw(0, 8'h20, 8'h00);
        rw(0, 8'h55, 8'h00);
        rw(1, 8'h22, 8'hFF);
        rw(0, 8'h22, 8'h00);
        s = 5'($urandom);
        channelEnable = ~(32'h1 << s);
        frame(s, 24'h400000, r0);
        checkVal("disabled slot ignored", 24'h0, r0);
        channelEnable = '1;
        frame(s, 24'h200000, r0);
        frame(s + 5'h1, 24'hD00000, r1);
        checkVal("largest magnitude tracked", 1, r1 > r0);
        headroom_offset_sel = 3'h4;
        frame(s, 24'h000000, r2);
        checkVal("headroom offset added", 1, r2 > r1);
        tracking_gain_sel = 8'hED;
        frame(s, 24'h000000, r0);
        checkVal("deep attenuation", 1, r0 < (r2 >> 10));
        tracking_gain_sel = 8'h00;
        headroom_offset_sel = 3'h7;
        frame(s, 24'h7FFFFF, r0);
        checkVal("saturated reference", 24'h7FFFFF, r0);
        @(negedge clk_sys);
        checkVal("intOut on unmasked clip", 1, intOut);
        rw(0, 8'h22, 8'h10);
        rw(0, 8'h20, 8'h10);
        for (int sel = 0; sel < 16; sel++) begin
            groupDelaySel = 4'(sel);
            d = MIN_D + sel * (MAX_D - MIN_D) / 15;
            audio(2'($urandom), 24'($urandom) & 24'h3FFFFF, ok);
            n = 0;
            while (dacValid !== 1'b1 && n < 100) begin
                @(negedge clk_sys);
                n++;
            end
            checkVal("group delay", 1, n >= d && n <= d + 2);
        end
        drain(0);
        groupDelaySel = 4'h0;
        dacReady = 1'b0;
        for (n = 0; n < 300; n++) begin
            audio(2'($urandom), 24'($urandom) & 24'h3FFFFF, ok);
            if (!ok) break;
        end
        checkVal("store refuses when full", 1, !ok && n >= 256 && n <= 266);
        drain(1);
        rw(0, 8'h22, 8'h00);
        audio(2'h2, 24'h7FFFFF, ok);
        drain(0);
        checkVal("intOut on audio clip", 1, intOut);
        rw(0, 8'h22, 8'h04);
        rw(0, 8'h20, 8'h14);
        rw(0, 8'h22, 8'h00);
        autoMaskOff = 1'b1;
        rw(1, 8'h20, 8'h00);
        audio(2'h0, 24'h800000, ok);
        drain(0);
        checkVal("intOut on negative clip", 1, intOut);
        rw(0, 8'h22, 8'h01);
        rw(0, 8'h20, 8'h00);
        rw(1, 8'h20, 8'h1F);
        audio(2'h1, 24'h7FFFFF, ok);
        drain(0);
        checkVal("masked clip keeps pin low", 0, intOut);
        rw(0, 8'h22, 8'h02);
        repeat (3) @(negedge clk_sys);
        print_verdict();
    end
endmodule : envelope_tracking_reference_tb
